// >>> rtl/hspwm_defs.svh
`ifndef HSPWM_DEFS_SVH
`define HSPWM_DEFS_SVH
// Register byte offsets
`define HSPWM_OFS_SRC_A     8'h00
`define HSPWM_OFS_SRC_B     8'h04
`define HSPWM_OFS_DUTY1     8'h08
`define HSPWM_OFS_DUTY2     8'h0c
`define HSPWM_OFS_FREQ      8'h10
`define HSPWM_OFS_OC_STAT   8'h14
`define HSPWM_OFS_OL_STAT   8'h18
`define HSPWM_OFS_MODE      8'h1c
`define HSPWM_OFS_PROT      8'h20
// Source select codes (3 bits per output)
`define HSPWM_SRC_OFF       3'h0
`define HSPWM_SRC_ON        3'h1
`define HSPWM_SRC_TMR1      3'h2
`define HSPWM_SRC_TMR2      3'h3
`define HSPWM_SRC_PWM1      3'h4
`define HSPWM_SRC_PWM2      3'h5
// Chip mode codes
`define HSPWM_MODE_NORMAL   3'h0
`define HSPWM_MODE_STOP     3'h1
`define HSPWM_MODE_SLEEP    3'h2
`define HSPWM_MODE_RESTART  3'h3
`define HSPWM_MODE_FAILSAFE 3'h4
// Timing, 100 MHz clock
`define HSPWM_CLK_HZ        100000000
`define HSPWM_F_LOW_HZ      200
`define HSPWM_F_HIGH_HZ     400
`define HSPWM_SLICE_LOW     ((`HSPWM_CLK_HZ / `HSPWM_F_LOW_HZ) / 256)
`define HSPWM_SLICE_HIGH    ((`HSPWM_CLK_HZ / `HSPWM_F_HIGH_HZ) / 256)
`define HSPWM_OC_FILT_US    16
`define HSPWM_OL_FILT_US    64
`define HSPWM_OC_FILT_CYC   (`HSPWM_OC_FILT_US * (`HSPWM_CLK_HZ / 1000000))
`define HSPWM_OL_FILT_CYC   (`HSPWM_OL_FILT_US * (`HSPWM_CLK_HZ / 1000000))
`define HSPWM_HTRANS_NONSEQ 2'h2
`endif

// >>> rtl/hspwm_pkg.sv
`default_nettype none
package hspwm_pkg;
    typedef logic [2:0] hspwm_src_type;
    typedef struct packed {
        logic [1:0] htrans;
        logic       hwrite;
        logic [7:0] haddr;
        logic       hsel;
    } hspwm_addr_type;
    typedef enum logic [1:0] {
        HSPWM_CTL_NORMAL = 2'b00,
        HSPWM_CTL_LOCKED = 2'b01,
        HSPWM_CTL_FORCED = 2'b10
    } hspwm_ctl_type;
endpackage : hspwm_pkg
`default_nettype wire

// >>> rtl/hspwm_top.sv
// Behaviour
// - Cyclic sense may drive outputs in low power
// - Protections stay active in stop and sleep
// - Configure in normal mode before low power
// - Low power freezes configuration except overcurrent source clears; configuration writes ignored
// - Restart and fail-safe force outputs off
// - Two independent PWM generators
// - Each generator has own 8-bit duty
// - Per-generator 200/400 Hz select, shared register
// - Each output selects timer or PWM source
// - PWM starts right after source selection
// - Overcurrent off after continuous filter time
// - Open load flagged after continuous filter time
// - Overcurrent clears source, sets sticky flag
// - Open-load flags sticky; output stays on
`include "hspwm_defs.svh"
`default_nettype none
module hspwm_top (
    input  wire logic        CLK,
    input  wire logic        RST_B,
    input  wire logic        HSEL,
    input  wire logic [7:0]  HADDR,
    input  wire logic [1:0]  HTRANS,
    input  wire logic        HWRITE,
    input  wire logic [2:0]  HSIZE,
    input  wire logic [31:0] HWDATA,
    input  wire logic        HREADY,
    output logic      [31:0] HRDATA,
    output logic             HREADYOUT,
    output logic             HRESP,
    input  wire logic [2:0]  CHIP_MODE,
    input  wire logic [1:0]  TIMER_OUT,
    input  wire logic [3:0]  CYCLIC_SENSE_REQ,
    input  wire logic [3:0]  OVERCURRENT_IN,
    input  wire logic [3:0]  UNDERCURRENT_IN,
    input  wire logic        SUPPLY_OV,
    input  wire logic        SUPPLY_UV,
    output logic      [3:0]  HIGH_SIDE_OUTPUT
);
    // Bus side overview
    // The slave answers every transfer with zero wait states and an OKAY response.
    // The address phase is captured at the edge where HSEL, HREADY and NONSEQ stand.
    // A write then lands at the following edge, using the captured address
    // and the write data that the master drives in the data phase.
    // A read is decoded straight from the live address phase.
    // Its data is registered at the same edge, so it stands for the whole data phase.
    // HSIZE is not decoded, because only whole aligned words are expected.
    // A narrower access still moves the low bits of the addressed register.
    // Unmapped writes are dropped and unmapped reads return zero.
    // Address phase capture
    hspwm_pkg::hspwm_addr_type aph_reg;
    hspwm_pkg::hspwm_addr_type aph_next;
    logic [11:0] output_source_select_a_reg;
    logic [1:0]  frequency_reg;
    logic [7:0]  first_generator_duty_reg;
    logic [7:0]  second_generator_duty_reg;
    logic [3:0]  output_overcurrent_flag_reg;
    logic [3:0]  output_open_load_flag_reg;
    logic [1:0]  prot_en_reg;
    logic [3:0]  pwm_raw;
    logic [3:0]  hs_on;
    logic [31:0] rd_mux;
    hspwm_pkg::hspwm_ctl_type ctl_state;

    assign aph_next = '{htrans: HTRANS, hwrite: HWRITE, haddr: HADDR, hsel: HSEL & HREADY};
    assign HREADYOUT = 1'b1;
    assign HRESP     = 1'b0;

    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            aph_reg <= '0;
        end else begin
            aph_reg <= aph_next;
        end
    end

    // Chip mode handling
    // Stop and sleep keep the configuration that was written in normal mode, except a source field that an overcurrent trip clears.
    // Configuration writes are refused there, so software cannot change a
    // low-power setup halfway through; the status flags stay clearable.
    // Restart and fail-safe only gate the outputs and leave the configuration.
    // Software can therefore switch the outputs back on once the fault is gone,
    // simply by rewriting or keeping the source fields.
    // Undefined mode codes behave as normal mode, the safest reading for a
    // code that a host should never send.
    // The mode input is a level and is not filtered here.
    // Mode decode: lock config in low power, force off in restart/fail-safe
    wire mode_low    = (CHIP_MODE == `HSPWM_MODE_STOP) || (CHIP_MODE == `HSPWM_MODE_SLEEP);
    wire mode_forced = (CHIP_MODE == `HSPWM_MODE_RESTART) || (CHIP_MODE == `HSPWM_MODE_FAILSAFE);
    assign ctl_state = mode_forced ? hspwm_pkg::HSPWM_CTL_FORCED :
                       mode_low    ? hspwm_pkg::HSPWM_CTL_LOCKED :
                                     hspwm_pkg::HSPWM_CTL_NORMAL;
    wire cfg_wr_ok = (ctl_state != hspwm_pkg::HSPWM_CTL_LOCKED);
    wire wr_act    = aph_reg.hsel && aph_reg.htrans == `HSPWM_HTRANS_NONSEQ && aph_reg.hwrite;
    wire wr_src_a  = wr_act && cfg_wr_ok && aph_reg.haddr == `HSPWM_OFS_SRC_A;
    wire wr_src_b  = wr_act && cfg_wr_ok && aph_reg.haddr == `HSPWM_OFS_SRC_B;
    wire wr_duty1  = wr_act && cfg_wr_ok && aph_reg.haddr == `HSPWM_OFS_DUTY1;
    wire wr_duty2  = wr_act && cfg_wr_ok && aph_reg.haddr == `HSPWM_OFS_DUTY2;
    wire wr_freq   = wr_act && cfg_wr_ok && aph_reg.haddr == `HSPWM_OFS_FREQ;
    wire wr_prot   = wr_act && cfg_wr_ok && aph_reg.haddr == `HSPWM_OFS_PROT;
    wire wr_oc     = wr_act && aph_reg.haddr == `HSPWM_OFS_OC_STAT;
    wire wr_ol     = wr_act && aph_reg.haddr == `HSPWM_OFS_OL_STAT;

    // PWM generator structure
    // Each generator is a prescaler that cuts the period into 256 slices and
    // an 8-bit slice counter that wraps once per period.
    // The output is high while the slice count is below the duty value,
    // so a duty of N gives N active slices and a duty of zero stays low.
    // A duty of 255 leaves one inactive slice per period by design.
    // The slice length follows the frequency bit of that generator alone,
    // so the two generators run fully independently of each other.
    // Slice lengths are truncated to whole clocks, which makes the real
    // period a little shorter than the nominal one.
    // A duty or frequency change takes effect at once, without waiting for
    // the end of the running period; a short glitch period may follow.
    // Both generators free-run from reset and never stop.
    // PWM generators, one per duty channel
    logic [7:0] duty [2];
    assign duty[0] = first_generator_duty_reg;
    assign duty[1] = second_generator_duty_reg;
    logic [1:0] pwm_out;
    genvar g;
    generate
        for (g = 0; g < 2; g = g + 1) begin : gen_pwm
            logic [17:0] pre_reg;
            logic [7:0]  slice_reg;
            wire  [17:0] slice_len = frequency_reg[g] ? 18'(`HSPWM_SLICE_HIGH - 1)
                                                      : 18'(`HSPWM_SLICE_LOW - 1);
            wire         slice_end = (pre_reg >= slice_len);
            always_ff @(posedge CLK or negedge RST_B) begin
                if (!RST_B) begin
                    pre_reg   <= '0;
                    slice_reg <= '0;
                end else begin
                    pre_reg   <= slice_end ? 18'h0 : pre_reg + 18'h1;
                    slice_reg <= slice_end ? slice_reg + 8'h1 : slice_reg;
                end
            end
            assign pwm_out[g] = (slice_reg < duty[g]);
        end
    endgenerate

    // Output channels
    // Every output picks its drive from off, on, one of two timers or one of
    // the two generators, through a three-bit field of its own.
    // Undefined codes drive the output low.
    // With the field off, the cyclic sense request may drive the output, but
    // only in stop and sleep, where the wake inputs need their supply.
    // Selecting a generator starts the PWM drive on the next clock.
    // Each channel carries an overcurrent and an open-load filter counter.
    // Both counters restart whenever the output is off, so a PWM low phase
    // also restarts them; short duties can hide a fault for that reason.
    // Per-output source selection and protection filters
    logic [3:0] oc_trip;
    logic [3:0] ol_trip;
    genvar h;
    generate
        for (h = 0; h < 4; h = h + 1) begin : gen_out
            logic [10:0] oc_cnt_reg;
            logic [12:0] ol_cnt_reg;
            wire  [2:0]  src = output_source_select_a_reg[3*h +: 3];
            always_comb begin
                case (src)
                    `HSPWM_SRC_OFF:  pwm_raw[h] = CYCLIC_SENSE_REQ[h] & mode_low;
                    `HSPWM_SRC_ON:   pwm_raw[h] = 1'b1;
                    `HSPWM_SRC_TMR1: pwm_raw[h] = TIMER_OUT[0];
                    `HSPWM_SRC_TMR2: pwm_raw[h] = TIMER_OUT[1];
                    `HSPWM_SRC_PWM1: pwm_raw[h] = pwm_out[0];
                    `HSPWM_SRC_PWM2: pwm_raw[h] = pwm_out[1];
                    default:         pwm_raw[h] = 1'b0;
                endcase
            end
            // The counter saturates at the trip point instead of wrapping,
            // so a held fault cannot roll the count over and lose the trip.
            // The trip itself lasts while the fault and the drive stand.
            // Once the field is cleared the drive falls and the count restarts.
            // A single clean sample is enough to restart the filter.
            // The filter runs in every chip mode.
            // Overcurrent must persist while on for the whole filter time
            always_ff @(posedge CLK or negedge RST_B) begin
                if (!RST_B) begin
                    oc_cnt_reg <= '0;
                end else if (hs_on[h] && OVERCURRENT_IN[h]) begin
                    oc_cnt_reg <= oc_trip[h] ? oc_cnt_reg : oc_cnt_reg + 11'h1;
                end else begin
                    oc_cnt_reg <= '0;
                end
            end
            assign oc_trip[h] = (oc_cnt_reg >= 11'(`HSPWM_OC_FILT_CYC - 1)) && OVERCURRENT_IN[h]
                                && hs_on[h];
            // Open load is judged only while the output is driven on.
            // The count also saturates, so a lasting open load keeps its trip
            // high and the sticky flag cannot be cleared while it stands.
            // Unlike overcurrent, the trip does not touch the drive.
            // A single sample with load current restarts the filter.
            // The filter runs in every chip mode.
            // Open load must persist while on for the whole filter time
            always_ff @(posedge CLK or negedge RST_B) begin
                if (!RST_B) begin
                    ol_cnt_reg <= '0;
                end else if (hs_on[h] && UNDERCURRENT_IN[h]) begin
                    ol_cnt_reg <= ol_trip[h] ? ol_cnt_reg : ol_cnt_reg + 13'h1;
                end else begin
                    ol_cnt_reg <= '0;
                end
            end
            assign ol_trip[h] = (ol_cnt_reg >= 13'(`HSPWM_OL_FILT_CYC - 1)) && UNDERCURRENT_IN[h]
                                && hs_on[h];
        end
    endgenerate

    // Output gating
    // Supply over-voltage and under-voltage each switch all outputs off while
    // their enable bit is set; both enables are set from reset.
    // The outputs return to their programmed state once the supply recovers,
    // because the configuration is never touched by a supply fault.
    // Restart and fail-safe gate the outputs in the same place.
    // The gated drive feeds both the filters and the output flops, so a gated
    // output can neither trip nor flag a load fault.
    // Supply shutdowns apply in every mode when enabled
    wire supply_off = (prot_en_reg[0] & SUPPLY_OV) | (prot_en_reg[1] & SUPPLY_UV);
    assign hs_on = (ctl_state == hspwm_pkg::HSPWM_CTL_FORCED || supply_off) ? 4'h0
                                                                            : pwm_raw;

    // Source field update
    // Both source words live in one twelve-bit vector, three bits per output.
    // A host write replaces the two fields of its word.
    // An overcurrent trip then overrides the field of its own output, so the
    // trip wins even over a write in the same cycle.
    // The trip lasts only until the cleared field drops the drive.
    // Software must write a source other than off to bring the output back.
    // Clearing the sticky flag first is the recommended order.
    // Source field next value: overcurrent clears the field, host write otherwise
    logic [11:0] src_next;
    always_comb begin
        src_next = output_source_select_a_reg;
        if (wr_src_a) begin
            src_next[5:0] = HWDATA[5:0];
        end
        if (wr_src_b) begin
            src_next[11:6] = HWDATA[5:0];
        end
        for (int i = 0; i < 4; i++) begin
            if (oc_trip[i]) begin
                src_next[3*i +: 3] = `HSPWM_SRC_OFF;
            end
        end
    end

    // Configuration storage
    // All configuration resets to off, zero duty and the low frequency.
    // Only the supply shutdown enables come up set, so a fresh device is
    // protected before software has written anything.
    // The write strobes already carry the low-power lock.
    // Upper data bits of every write are ignored.
    // Configuration registers
    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            output_source_select_a_reg <= '0;
            first_generator_duty_reg   <= '0;
            second_generator_duty_reg  <= '0;
            frequency_reg              <= '0;
            prot_en_reg                <= 2'h3;
        end else begin
            output_source_select_a_reg <= src_next;
            if (wr_duty1) begin
                first_generator_duty_reg <= HWDATA[7:0];
            end
            if (wr_duty2) begin
                second_generator_duty_reg <= HWDATA[7:0];
            end
            if (wr_freq) begin
                frequency_reg <= HWDATA[1:0];
            end
            if (wr_prot) begin
                prot_en_reg <= HWDATA[1:0];
            end
        end
    end

    // Status flags
    // One overcurrent and one open-load flag per output, both sticky.
    // Software clears a flag by writing one to its bit.
    // A trip in the same cycle as the clear keeps the flag set, so an event
    // can never be lost between a read and the following clear.
    // The flags stay clearable in every chip mode.
    // A held open load sets its flag again at once after every clear.
    // Nothing clears a flag on its own.
    // Sticky flags: set wins over write-one-to-clear
    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            output_overcurrent_flag_reg <= '0;
            output_open_load_flag_reg   <= '0;
        end else begin
            output_overcurrent_flag_reg <= (output_overcurrent_flag_reg
                                           & ~(wr_oc ? HWDATA[3:0] : 4'h0)) | oc_trip;
            output_open_load_flag_reg   <= (output_open_load_flag_reg
                                           & ~(wr_ol ? HWDATA[3:0] : 4'h0)) | ol_trip;
        end
    end

    // Read path
    // The mux decodes the live address, so the data is ready to register
    // at the address-phase edge and stands through the data phase.
    // Outside a read data phase the bus shows zero, which keeps stale
    // values off the bus.
    // The mode word reads back the live chip mode.
    // Source words read back as two fields each.
    // Read mux, unmapped reads zero
    wire rd_act = aph_next.hsel && HTRANS == `HSPWM_HTRANS_NONSEQ && !HWRITE;
    always_comb begin
        case (HADDR)
            `HSPWM_OFS_SRC_A:   rd_mux = {26'h0, output_source_select_a_reg[5:0]};
            `HSPWM_OFS_SRC_B:   rd_mux = {26'h0, output_source_select_a_reg[11:6]};
            `HSPWM_OFS_DUTY1:   rd_mux = {24'h0, first_generator_duty_reg};
            `HSPWM_OFS_DUTY2:   rd_mux = {24'h0, second_generator_duty_reg};
            `HSPWM_OFS_FREQ:    rd_mux = {30'h0, frequency_reg};
            `HSPWM_OFS_OC_STAT: rd_mux = {28'h0, output_overcurrent_flag_reg};
            `HSPWM_OFS_OL_STAT: rd_mux = {28'h0, output_open_load_flag_reg};
            `HSPWM_OFS_MODE:    rd_mux = {29'h0, CHIP_MODE};
            `HSPWM_OFS_PROT:    rd_mux = {30'h0, prot_en_reg};
            default:            rd_mux = 32'h0;
        endcase
    end

    // Output flops
    // The switch drives leave from flops, one clock after the gating.
    // An overcurrent trip masks the drive in the very cycle it fires, so the
    // output falls at the same edge at which the field is cleared.
    // Without that mask the switch would stay on one clock longer than the
    // filter time.
    // Read data is registered here as well.
    // Both reset to zero, so all switches are off during reset.
    // Registered read data and outputs
    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            HRDATA           <= '0;
            HIGH_SIDE_OUTPUT <= '0;
        end else begin
            HRDATA           <= rd_act ? rd_mux : 32'h0;
            HIGH_SIDE_OUTPUT <= hs_on & ~oc_trip;
        end
    end
endmodule : hspwm_top
`default_nettype wire

// >>> sim/hspwm_load.sv
`default_nettype none
module hspwm_load (
    input  wire logic [3:0] drive,
    input  wire logic [3:0] short_en,
    input  wire logic [3:0] open_en,
    output logic      [3:0] over_i,
    output logic      [3:0] under_i
);
    // Current flows only through a load whose switch is on
    assign over_i  = drive & short_en;
    // A switched-off or broken load draws nothing
    assign under_i = ~drive | open_en;
endmodule : hspwm_load
`default_nettype wire

// >>> sim/hspwm_asserts.sv
`default_nettype none
module hspwm_asserts (
    input wire logic        CLK,
    input wire logic        RST_B,
    input wire logic        HSEL,
    input wire logic [1:0]  HTRANS,
    input wire logic        HWRITE,
    input wire logic        HREADY,
    input wire logic [31:0] HRDATA,
    input wire logic        HREADYOUT,
    input wire logic        HRESP,
    input wire logic [2:0]  CHIP_MODE,
    input wire logic [3:0]  OVERCURRENT_IN,
    input wire logic [3:0]  HIGH_SIDE_OUTPUT
);
    logic        rd_reg;
    logic [15:0] oc_reg;
    // Read data phase and overcurrent run length on output 0
    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            rd_reg <= 1'h0;
            oc_reg <= 16'h0;
        end else begin
            rd_reg <= HSEL & HREADY & (HTRANS == 2'h2) & !HWRITE;
            oc_reg <= (OVERCURRENT_IN[0] & HIGH_SIDE_OUTPUT[0]) ? oc_reg + 16'h1 : 16'h0;
        end
    end
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RST_B);
    property p_okay; HRESP == 1'h0; endproperty
    a_okay: assert property (p_okay)
        else $error("error response");
    property p_ready; HREADYOUT == 1'h1; endproperty
    a_ready: assert property (p_ready)
        else $error("wait state inserted");
    property p_rd_idle; !rd_reg |-> HRDATA == 32'h0; endproperty
    a_rd_idle: assert property (p_rd_idle)
        else $error("read data outside data phase");
    property p_rd_high; rd_reg |-> HRDATA[31:8] == 24'h0; endproperty
    a_rd_high: assert property (p_rd_high)
        else $error("upper read bits set");
    property p_restart; CHIP_MODE == 3'h3 |=> HIGH_SIDE_OUTPUT == 4'h0; endproperty
    a_restart: assert property (p_restart)
        else $error("output on in restart");
    property p_failsafe; CHIP_MODE == 3'h4 [*2] |=> HIGH_SIDE_OUTPUT == 4'h0; endproperty
    a_failsafe: assert property (p_failsafe)
        else $error("output on in fail-safe");
    property p_rst_out; $rose(RST_B) |-> HIGH_SIDE_OUTPUT == 4'h0; endproperty
    a_rst_out: assert property (p_rst_out)
        else $error("output on after reset");
    property p_oc_limit; oc_reg <= 16'd1601; endproperty
    a_oc_limit: assert property (p_oc_limit)
        else $error("overcurrent not switched off");
endmodule : hspwm_asserts
bind hspwm_top hspwm_asserts u_hspwm_asserts (.CLK(CLK), .RST_B(RST_B), .HSEL(HSEL),
    .HTRANS(HTRANS), .HWRITE(HWRITE), .HREADY(HREADY), .HRDATA(HRDATA),
    .HREADYOUT(HREADYOUT), .HRESP(HRESP), .CHIP_MODE(CHIP_MODE),
    .OVERCURRENT_IN(OVERCURRENT_IN), .HIGH_SIDE_OUTPUT(HIGH_SIDE_OUTPUT));
`default_nettype wire

// >>> sim/hspwm_top_tb.sv
`include "hspwm_defs.svh"
`default_nettype none
module hspwm_top_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk = 1'h0, rst_b = 1'h0, hsel = 1'h0, hwrite = 1'h0;
    logic        rd_dp = 1'h0, look = 1'h0, hready, hresp, sup_ov = 1'h0;
    logic [1:0]  htrans = 2'h0, tmr = 2'h0;
    logic [2:0]  mode = 3'h0;
    logic [3:0]  sense = 4'h0, shorts = 4'h0, opens = 4'h0, oc_i, ul_i, hso;
    logic [7:0]  haddr = 8'h0, duty;
    logic [31:0] hwdata = 32'h0, hrdata;
    logic [31:0] exp_q[$];
    int          bad_count = 0, n_checks = 0;
    always #5 clk = ~clk;
    hspwm_top u_hspwm_top (.CLK(clk), .RST_B(rst_b), .HSEL(hsel), .HADDR(haddr),
        .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(3'h2), .HWDATA(hwdata), .HREADY(hready),
        .HRDATA(hrdata), .HREADYOUT(hready), .HRESP(hresp), .CHIP_MODE(mode),
        .TIMER_OUT(tmr), .CYCLIC_SENSE_REQ(sense), .OVERCURRENT_IN(oc_i),
        .UNDERCURRENT_IN(ul_i), .SUPPLY_OV(sup_ov), .SUPPLY_UV(1'h0), .HIGH_SIDE_OUTPUT(hso));
    hspwm_load u_hspwm_load (.drive(hso), .short_en(shorts), .open_en(opens),
        .over_i(oc_i), .under_i(ul_i));
    task automatic complete_run();
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : complete_run
    task automatic check(input string what, input logic [31:0] seen, want);
        n_checks++;
        if (seen !== want) begin
            bad_count++;
            $display("unexpected %s: expected %h seen %h", what, want, seen);
        end
    endtask : check
    task automatic wait_rdy();
        int i;
        for (i = 0; i < 50; i++) begin
            @(posedge clk);
            if (hready === 1'h1) break;
        end
        if (i == 50) begin
            bad_count++;
            complete_run();
        end
    endtask : wait_rdy
    // One AHB single transfer; a read notes its expected data
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        hsel   <= 1'h1;
        haddr  <= a;
        hwrite <= w;
        htrans <= 2'h2;
        wait_rdy();
        htrans <= 2'h0;
        hwdata <= d;
        rd_dp  <= !w;
        if (!w) exp_q.push_back(d);
        wait_rdy();
        rd_dp <= 1'h0;
    endtask : bus
    task automatic outs(input logic [3:0] v);
        @(posedge clk);
        exp_q.push_back({28'h0, v});
        look <= 1'h1;
        @(posedge clk);
        look <= 1'h0;
    endtask : outs
    // Compare the oldest note with the read data or the outputs
    always @(posedge clk) begin
        if (rd_dp) check("read data", hrdata, exp_q.pop_front());
        if (look) check("outputs", {28'h0, hso}, exp_q.pop_front());
    end
    initial begin
        void'($urandom(32'h6549));
        duty = 8'($urandom_range(255, 4));
        repeat (20) @(posedge clk);
        rst_b <= 1'h1;
        @(posedge clk);
        // Configure in normal mode: duties, frequency, sources
        bus(1'h1, `HSPWM_OFS_DUTY1, {24'h0, duty});
        bus(1'h1, `HSPWM_OFS_DUTY2, 32'h0);
        bus(1'h1, `HSPWM_OFS_FREQ, 32'h2);
        bus(1'h1, `HSPWM_OFS_SRC_A, 32'h11);
        bus(1'h1, `HSPWM_OFS_SRC_B, 32'h2b);
        bus(1'h0, `HSPWM_OFS_DUTY1, {24'h0, duty});
        bus(1'h0, `HSPWM_OFS_DUTY2, 32'h0);
        bus(1'h0, `HSPWM_OFS_FREQ, 32'h2);
        bus(1'h0, 8'h40, 32'h0);
        tmr <= 2'h2;
        outs(4'h5);
        tmr <= 2'h1;
        outs(4'h3);
        tmr <= 2'h0;
        sense <= 4'h8;
        bus(1'h1, `HSPWM_OFS_SRC_B, 32'h03);
        outs(4'h1);
        // Walk stop, sleep, restart and fail-safe
        for (int m = 1; m < 5; m++) begin
            mode <= 3'(m);
            outs((m < 3) ? 4'h9 : 4'h0);
            if (m == 1) bus(1'h1, `HSPWM_OFS_SRC_A, 32'h0);
            if (m == 1) bus(1'h0, `HSPWM_OFS_SRC_A, 32'h11);
        end
        mode <= 3'h0;
        sense <= 4'h0;
        outs(4'h1);
        // Overcurrent on output 0 through the full filter time
        shorts <= 4'h1;
        repeat (1500) @(posedge clk);
        outs(4'h1);
        repeat (200) @(posedge clk);
        outs(4'h0);
        bus(1'h0, `HSPWM_OFS_SRC_A, 32'h10);
        bus(1'h0, `HSPWM_OFS_OC_STAT, 32'h1);
        shorts <= 4'h0;
        bus(1'h1, `HSPWM_OFS_OC_STAT, 32'h1);
        bus(1'h1, `HSPWM_OFS_SRC_A, 32'h11);
        bus(1'h0, `HSPWM_OFS_OC_STAT, 32'h0);
        outs(4'h1);
        // Open load on output 0
        opens <= 4'h1;
        repeat (6000) @(posedge clk);
        bus(1'h0, `HSPWM_OFS_OL_STAT, 32'h0);
        repeat (600) @(posedge clk);
        bus(1'h0, `HSPWM_OFS_OL_STAT, 32'h1);
        outs(4'h1);
        opens <= 4'h0;
        bus(1'h1, `HSPWM_OFS_OL_STAT, 32'h1);
        bus(1'h0, `HSPWM_OFS_OL_STAT, 32'h0);
        // Supply over-voltage gates all outputs until its shutdown is disabled
        sup_ov <= 1'h1;
        outs(4'h0);
        bus(1'h1, `HSPWM_OFS_PROT, 32'h2);
        outs(4'h1);
        sup_ov <= 1'h0;
        // Generator two on output 3 at full duty, then at zero duty
        bus(1'h1, `HSPWM_OFS_DUTY2, 32'hff);
        bus(1'h1, `HSPWM_OFS_SRC_B, 32'h2b);
        outs(4'h9);
        bus(1'h1, `HSPWM_OFS_DUTY2, 32'h0);
        outs(4'h1);
        complete_run();
    end
endmodule : hspwm_top_tb
`default_nettype wire
